// File: design/artmr_top.v
// Notes on behaviour
// - counter is low byte plus high byte; split bit picks 16-bit or two 8-bit
// - count clocks: system clock, system clock/12, synchronized external oscillator/8
// - 16-bit mode increments per tick; on full wrap loads reload value, sets high flag
// - 16-bit mode with interrupt enabled requests on every full wrap
// - 16-bit mode with low interrupt enable also requests on low byte wrap
// - split mode runs two 8-bit counters, each reloading its own reload byte
// - split mode: run bit gates only the high byte; low byte always counts
// - per-byte system_clock select; else external select picks /12 or external/8
// - split mode: high wrap sets high flag, low wrap sets low flag
// - split mode interrupts on high wrap, plus low wrap if low enable set
// - hardware never clears overflow flags; software clears and inspects both
// - capture mode counts on system clock or /12 per low select
// - capture event copies 16-bit count into reload pair and sets high flag
// - capture event on each falling edge of external oscillator/8
// - capture-enable bit 1 enters capture mode, 0 leaves it off
// - control bits 7,6,5,4,3,2,0 as flags, enables, split, run, xclk; reset zero
`include "artmr_map.vh"
`default_nettype none

module artmr_top (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        SYS_RST,
  // external oscillator pin
  input  wire        EXT_OSC,
  // axi4-lite write address
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  // axi4-lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // axi4-lite read address
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  // axi4-lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // interrupt request to the core
  output reg         TIMER_IRQ
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]  count_low_byte;
  reg [7:0]  count_high_byte;
  reg [7:0]  reload_low_byte;
  reg [7:0]  reload_high_byte;
  reg        high_overflow_flag;
  reg        low_overflow_flag;
  reg        low_overflow_irq_enable;
  reg        capture_enable_bit;
  reg        split_mode_bit;
  reg        run_control_bit;
  reg        external_clock_select;
  reg        low_byte_system_clock_select;
  reg        high_byte_system_clock_select;
  reg        timer_irq_enable;

  // ----------------------------------------
  // bus slave state
  // ----------------------------------------
  reg [9:0]  aw_index;
  reg        aw_held;
  reg [7:0]  w_byte;
  reg        w_lane0;
  reg        w_held;
  wire       aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire       w_take  = S_AXI_WVALID & S_AXI_WREADY;
  wire       ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire       wr_fire = aw_held & w_held & ~S_AXI_BVALID;
  wire       wr_en   = wr_fire & w_lane0;
  wire       wr_ctl  = wr_en & (aw_index == `ARTMR_IDX_CTRL);
  wire       wr_rll  = wr_en & (aw_index == `ARTMR_IDX_RELOAD_LO);
  wire       wr_rlh  = wr_en & (aw_index == `ARTMR_IDX_RELOAD_HI);
  wire       wr_cl   = wr_en & (aw_index == `ARTMR_IDX_COUNT_LO);
  wire       wr_ch   = wr_en & (aw_index == `ARTMR_IDX_COUNT_HI);
  wire       wr_ckc  = wr_en & (aw_index == `ARTMR_IDX_CLKCTL);
  wire       aw_hit  = (aw_index >= `ARTMR_IDX_CTRL) & (aw_index <= `ARTMR_IDX_CLKCTL);

  // ----------------------------------------
  // clock sources
  // ----------------------------------------
  reg [3:0]  div12;
  reg        osc_s1;
  reg        osc_s2;
  reg        osc_s3;
  reg        osc_filt;
  reg        osc_filt_d;
  reg [2:0]  div8;
  wire       tick12   = (div12 == `ARTMR_DIV12_LAST);
  wire       osc_rise = osc_filt & ~osc_filt_d;
  // msb of div8 falls here: one tick per external/8 period
  wire       ext_tick = osc_rise & (div8 == `ARTMR_DIV8_LAST);

  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div12      <= 4'h0;
      osc_s1     <= 1'b0;
      osc_s2     <= 1'b0;
      osc_s3     <= 1'b0;
      osc_filt   <= 1'b0;
      osc_filt_d <= 1'b0;
      div8       <= 3'h0;
    end else begin
      div12 <= tick12 ? 4'h0 : div12 + 4'h1;
      osc_s1 <= EXT_OSC;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      // level accepted only when two stages agree
      if (osc_s2 == osc_s3) begin
        osc_filt <= osc_s3;
      end
      osc_filt_d <= osc_filt;
      // oscillator must stay well below half the system clock
      if (osc_rise) begin
        div8 <= div8 + 3'h1;
      end
    end
  end

  // per-byte tick selection
  wire tick_lo  = low_byte_system_clock_select ? 1'b1 :
                  (external_clock_select ? ext_tick : tick12);
  wire tick_hi  = high_byte_system_clock_select ? 1'b1 :
                  (external_clock_select ? ext_tick : tick12);
  wire tick_cap = low_byte_system_clock_select ? 1'b1 : tick12;

  // ----------------------------------------
  // counter next state
  // ----------------------------------------
  reg [7:0] next_count_low;
  reg [7:0] next_count_high;
  reg       set_high;
  reg       set_low;
  reg       capture;

  always @* begin
    next_count_low  = count_low_byte;
    next_count_high = count_high_byte;
    set_high        = 1'b0;
    set_low         = 1'b0;
    capture         = 1'b0;
    if (capture_enable_bit) begin
      capture  = ext_tick;
      set_high = ext_tick;
      if (run_control_bit & tick_cap) begin
        // overflow here wraps to zero; the reload pair holds capture data
        next_count_low = count_low_byte + 8'h01;
        if (count_low_byte == 8'hff) begin
          set_low         = 1'b1;
          next_count_high = count_high_byte + 8'h01;
        end
      end
    end else if (!split_mode_bit) begin
      if (run_control_bit & tick_lo) begin
        if (count_low_byte == 8'hff) begin
          set_low = 1'b1;
          if (count_high_byte == 8'hff) begin
            next_count_low  = reload_low_byte;
            next_count_high = reload_high_byte;
            set_high        = 1'b1;
          end else begin
            next_count_low  = 8'h00;
            next_count_high = count_high_byte + 8'h01;
          end
        end else begin
          next_count_low = count_low_byte + 8'h01;
        end
      end
    end else begin
      if (tick_lo) begin
        if (count_low_byte == 8'hff) begin
          next_count_low = reload_low_byte;
          set_low        = 1'b1;
        end else begin
          next_count_low = count_low_byte + 8'h01;
        end
      end
      if (run_control_bit & tick_hi) begin
        if (count_high_byte == 8'hff) begin
          next_count_high = reload_high_byte;
          set_high        = 1'b1;
        end else begin
          next_count_high = count_high_byte + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // register update
  // ----------------------------------------
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_low_byte          <= `ARTMR_RST_BYTE;
      count_high_byte         <= `ARTMR_RST_BYTE;
      reload_low_byte         <= `ARTMR_RST_BYTE;
      reload_high_byte        <= `ARTMR_RST_BYTE;
      high_overflow_flag      <= `ARTMR_RST_BIT;
      low_overflow_flag       <= `ARTMR_RST_BIT;
      low_overflow_irq_enable <= `ARTMR_RST_BIT;
      capture_enable_bit      <= `ARTMR_RST_BIT;
      split_mode_bit          <= `ARTMR_RST_BIT;
      run_control_bit         <= `ARTMR_RST_BIT;
      external_clock_select   <= `ARTMR_RST_BIT;
      low_byte_system_clock_select  <= `ARTMR_RST_BIT;
      high_byte_system_clock_select <= `ARTMR_RST_BIT;
      timer_irq_enable        <= `ARTMR_RST_BIT;
      TIMER_IRQ               <= 1'b0;
    end else begin
      // software byte writes take priority over hardware updates
      count_low_byte  <= wr_cl ? w_byte : next_count_low;
      count_high_byte <= wr_ch ? w_byte : next_count_high;
      if (wr_rll) begin
        reload_low_byte <= w_byte;
      end else if (capture) begin
        reload_low_byte <= count_low_byte;
      end
      if (wr_rlh) begin
        reload_high_byte <= w_byte;
      end else if (capture) begin
        reload_high_byte <= count_high_byte;
      end
      // flags: a hardware set in the clearing cycle survives
      if (wr_ctl) begin
        high_overflow_flag      <= w_byte[`ARTMR_CTL_HFLAG] | set_high;
        low_overflow_flag       <= w_byte[`ARTMR_CTL_LFLAG] | set_low;
        low_overflow_irq_enable <= w_byte[`ARTMR_CTL_LIEN];
        capture_enable_bit      <= w_byte[`ARTMR_CTL_CAPEN];
        split_mode_bit          <= w_byte[`ARTMR_CTL_SPLIT];
        run_control_bit         <= w_byte[`ARTMR_CTL_RUN];
        external_clock_select   <= w_byte[`ARTMR_CTL_XCLK];
      end else begin
        high_overflow_flag <= high_overflow_flag | set_high;
        low_overflow_flag  <= low_overflow_flag | set_low;
      end
      if (wr_ckc) begin
        low_byte_system_clock_select  <= w_byte[`ARTMR_CKC_LOSYS];
        high_byte_system_clock_select <= w_byte[`ARTMR_CKC_HISYS];
        timer_irq_enable        <= w_byte[`ARTMR_CKC_IEN];
      end
      // level request while a flag that is enabled stands
      TIMER_IRQ <= timer_irq_enable &
                   (high_overflow_flag | (low_overflow_irq_enable & low_overflow_flag));
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] rd_byte;
  reg       rd_hit;
  wire [9:0] ar_index = S_AXI_ARADDR[11:2];

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ar_index)
      `ARTMR_IDX_CTRL: begin
        rd_byte = {high_overflow_flag, low_overflow_flag, low_overflow_irq_enable,
                   capture_enable_bit, split_mode_bit, run_control_bit, 1'b0,
                   external_clock_select};
      end
      `ARTMR_IDX_RELOAD_LO: begin
        rd_byte = reload_low_byte;
      end
      `ARTMR_IDX_RELOAD_HI: begin
        rd_byte = reload_high_byte;
      end
      `ARTMR_IDX_COUNT_LO: begin
        rd_byte = count_low_byte;
      end
      `ARTMR_IDX_COUNT_HI: begin
        rd_byte = count_high_byte;
      end
      `ARTMR_IDX_CLKCTL: begin
        rd_byte = {5'h00, timer_irq_enable, high_byte_system_clock_select,
                   low_byte_system_clock_select};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ARTMR_RESP_OKAY;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `ARTMR_RESP_OKAY;
      aw_index      <= 10'h000;
      aw_held       <= 1'b0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      w_held        <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_index      <= S_AXI_AWADDR[11:2];
        aw_held       <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_take) begin
        w_byte       <= S_AXI_WDATA[7:0];
        w_lane0      <= S_AXI_WSTRB[0];
        w_held       <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      // one write in flight; ready returns once the response is taken
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= aw_hit ? `ARTMR_RESP_OKAY : `ARTMR_RESP_SLVERR;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
      if (ar_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= {24'h00_0000, rd_byte};
        S_AXI_RRESP   <= rd_hit ? `ARTMR_RESP_OKAY : `ARTMR_RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule // artmr_top

`default_nettype wire

// File: pkg/artmr_map.vh
`ifndef ARTMR_MAP_VH
`define ARTMR_MAP_VH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ARTMR_IDX_CTRL      10'h091
`define ARTMR_IDX_RELOAD_LO 10'h092
`define ARTMR_IDX_RELOAD_HI 10'h093
`define ARTMR_IDX_COUNT_LO  10'h094
`define ARTMR_IDX_COUNT_HI  10'h095
`define ARTMR_IDX_CLKCTL    10'h096
// ----------------------------------------
// timer_control_reg fields
// ----------------------------------------
`define ARTMR_CTL_HFLAG     7
`define ARTMR_CTL_LFLAG     6
`define ARTMR_CTL_LIEN      5
`define ARTMR_CTL_CAPEN     4
`define ARTMR_CTL_SPLIT     3
`define ARTMR_CTL_RUN       2
`define ARTMR_CTL_XCLK      0
// ----------------------------------------
// clock_control_reg fields
// ----------------------------------------
`define ARTMR_CKC_LOSYS     0
`define ARTMR_CKC_HISYS     1
`define ARTMR_CKC_IEN       2
// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define ARTMR_RST_BYTE      8'h00
`define ARTMR_RST_BIT       1'b0
`define ARTMR_DIV12_LAST    4'hb
`define ARTMR_DIV8_LAST     3'h7
`define ARTMR_RESP_OKAY     2'h0
`define ARTMR_RESP_SLVERR   2'h2
`endif

// File: tb/artmr_osc_model.sv
`default_nettype none
module artmr_osc_model #(
  parameter int HALF_NS = 250
) (
  // control and pin
  input  wire logic en,
  output var  logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc = 1'b0;
  // stands low between bursts so no stray edges reach the filter
  always #(HALF_NS) osc = en ? ~osc : 1'b0;
endmodule // artmr_osc_model
`default_nettype wire

// File: tb/artmr_top_asserts.sv
`include "artmr_map.vh"
`default_nettype none
module artmr_top_asserts (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // write channels
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  // read channels
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // interrupt
  input wire logic        TIMER_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire logic [9:0] ridx = S_AXI_ARADDR[11:2];
  wire logic       rmap = (ridx >= `ARTMR_IDX_CTRL) && (ridx <= `ARTMR_IDX_CLKCTL);
  AST_WR_ANSWER: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID) else $error("write answer");
  AST_B_HOLD: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("bvalid dropped");
  AST_B_DONE: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write not closed");
  AST_RD_ANSWER: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer");
  AST_R_HOLD: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("rdata moved");
  AST_R_UPPER: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000) else $error("upper bits set");
  AST_R_UNMAPPED: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && !rmap
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
  AST_R_MAPPED: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && rmap |=> S_AXI_RRESP == 2'h0) else $error("mapped read");
  AST_IRQ_STAYS: assert property (
    $fell(TIMER_IRQ) |-> $past(S_AXI_BVALID)) else $error("irq fell alone");
endmodule // artmr_top_asserts
bind artmr_top artmr_top_asserts u_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

// File: tb/tb_auto_reload_timer_with_osc_capture.sv
`include "artmr_map.vh"
`default_nettype none
module tb_auto_reload_timer_with_osc_capture;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] CT = `ARTMR_IDX_CTRL;
  localparam logic [9:0] RL = `ARTMR_IDX_RELOAD_LO;
  localparam logic [9:0] RH = `ARTMR_IDX_RELOAD_HI;
  localparam logic [9:0] CL = `ARTMR_IDX_COUNT_LO;
  localparam logic [9:0] CH = `ARTMR_IDX_COUNT_HI;
  localparam logic [9:0] CK = `ARTMR_IDX_CLKCTL;
  logic        clk = 1'b0, rst = 1'b1, osc_en = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic   osc, awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [7:0]  d;

  always #25 clk = ~clk;

  artmr_osc_model u_osc (.en(osc_en), .osc(osc));
  artmr_top DUT (
    .REF_CLK(clk), .SYS_RST(rst), .EXT_OSC(osc),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TIMER_IRQ(irq));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ci(input logic e);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {6'h00, er}, {6'h00, bresp});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [1:0] er, output logic [7:0] v);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata[7:0];
    chk("rresp", {6'h00, er}, {6'h00, rresp});
  endtask

  task automatic rc(input string nm, input logic [9:0] idx, input logic [7:0] e);
    rd(idx, 2'h0, d);
    chk(nm, e, d);
  endtask

  task automatic rng(input string nm, input logic [7:0] lo, input logic [7:0] hi);
    chk(nm, 8'h01, {7'h00, (d >= lo) && (d <= hi)});
  endtask

  // waits for the high flag, takes the captured pair, clears the flag again
  task automatic cap16(output logic [15:0] v);
    d = 8'h00;
    for (int n = 0; n < 60 && !d[7]; n++) rd(CT, 2'h0, d);
    rd(RL, 2'h0, v[7:0]);
    rd(RH, 2'h0, v[15:8]);
    wr(CT, 8'h14, 2'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 'h091; i <= 'h096; i++) rc("reset", i[9:0], 8'h00);
    rd(10'h090, 2'h2, d);
    chk("unmapped", 8'h00, d);
    wr(10'h097, 8'h5a, 2'h2);
    // strobe bit 0 low: answered, register untouched
    wstrb <= 4'h0;
    wr(CL, 8'h33, 2'h0);
    wstrb <= 4'h1;
    rc("strobe off", CL, 8'h00);
    wr(CT, 8'hff, 2'h0);
    rc("ctrl rw", CT, 8'hfd);
    wr(CT, 8'h00, 2'h0);
  endtask

  task automatic t_16();
    wr(CK, 8'h05, 2'h0);
    wr(RL, 8'h34, 2'h0);
    wr(RH, 8'h12, 2'h0);
    wr(CL, 8'hf0, 2'h0);
    wr(CH, 8'hff, 2'h0);
    wr(CT, 8'h04, 2'h0);
    wt(40);
    rc("full wrap flags", CT, 8'hc4);
    ci(1'b1);
    wr(CT, 8'h00, 2'h0);
    rc("reload hi", CH, 8'h12);
    ci(1'b0);
    wr(CL, 8'hf8, 2'h0);
    wr(CH, 8'h00, 2'h0);
    wr(CT, 8'h04, 2'h0);
    wt(20);
    rc("low wrap flags", CT, 8'h44);
    ci(1'b0);
    wr(CT, 8'h60, 2'h0);
    wt(2);
    ci(1'b1);
    wr(CT, 8'h00, 2'h0);
  endtask

  task automatic t_split();
    wr(CK, 8'h05, 2'h0);
    wr(RL, 8'ha0, 2'h0);
    wr(CL, 8'hf0, 2'h0);
    wr(CH, 8'h05, 2'h0);
    wr(CT, 8'h08, 2'h0);
    wt(30);
    rc("split low flag", CT, 8'h48);
    ci(1'b0);
    rc("high idle", CH, 8'h05);
    rd(CL, 2'h0, d);
    rng("low reload", 8'ha0, 8'hff);
    wr(CK, 8'h07, 2'h0);
    wr(RH, 8'h40, 2'h0);
    wr(CH, 8'hf8, 2'h0);
    wr(CT, 8'h0c, 2'h0);
    wt(20);
    rd(CT, 2'h0, d);
    chk("split high flag", 8'h8c, d & 8'hbf);
    ci(1'b1);
    rd(CH, 2'h0, d);
    rng("high reload", 8'h40, 8'h7f);
    wr(CT, 8'h00, 2'h0);
  endtask

  task automatic t_clk();
    wr(CK, 8'h00, 2'h0);
    wr(CL, 8'h00, 2'h0);
    wr(CH, 8'h00, 2'h0);
    wr(CT, 8'h04, 2'h0);
    wt(240);
    wr(CT, 8'h00, 2'h0);
    rd(CL, 2'h0, d);
    rng("div12 ticks", 8'h13, 8'h15);
    wr(CL, 8'h00, 2'h0);
    osc_en <= 1'b1;
    wr(CT, 8'h05, 2'h0);
    wt(800);
    wr(CT, 8'h00, 2'h0);
    osc_en <= 1'b0;
    rd(CL, 2'h0, d);
    rng("ext div8 ticks", 8'h09, 8'h0b);
  endtask

  task automatic t_cap();
    logic [15:0] c1, c2, dl;
    wr(CK, 8'h01, 2'h0);
    wr(CL, 8'h78, 2'h0);
    wr(CH, 8'h56, 2'h0);
    // split kept cleared while capturing
    wr(CT, 8'h10, 2'h0);
    wt(100);
    rc("no edge no capture", RL, 8'ha0);
    osc_en <= 1'b1;
    wt(200);
    rc("capture flag", CT, 8'h90);
    rc("capture lo", RL, 8'h78);
    rc("capture hi", RH, 8'h56);
    wr(CT, 8'h14, 2'h0);
    wt(300);
    osc_en <= 1'b0;
    wt(20);
    wr(CT, 8'h00, 2'h0);
    rc("capture count", CH, 8'h57);
    rc("late capture", RH, 8'h57);
    // system_clock count: osc/8 period of 8 x 500 ns is 80 counts between captures
    osc_en <= 1'b1;
    wr(CT, 8'h14, 2'h0);
    cap16(c1);
    cap16(c2);
    wr(CT, 8'h00, 2'h0);
    osc_en <= 1'b0;
    dl = c2 - c1;
    chk("capture delta lo", 8'h50, dl[7:0]);
    chk("capture delta hi", 8'h00, dl[15:8]);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_16();
    t_split();
    t_clk();
    t_cap();
    results();
  end
endmodule // tb_auto_reload_timer_with_osc_capture
`default_nettype wire
